// *** core/rivam_prio_enc.v ***
// Fixed-priority encoder over the interrupt request vector.
// Assumes requests are already qualified by enables and legacy mode.
`timescale 1ns/1ns
`include "rivam_regs.vh"

module rivam_prio_enc (
  // Request vector, bit 0 is highest priority
  input  wire [`RIVAM_NUM_SRC-1:0] req_vec,
  // Winner
  output reg                       any_req,
  output reg  [`RIVAM_IDX_W-1:0]   win_idx
);

  integer i;

  // Scan from top down so the lowest index is the last to win
  always @* begin
    any_req = 1'b0;
    win_idx = {`RIVAM_IDX_W{1'b0}};
    for (i = `RIVAM_NUM_SRC-1; i >= 0; i = i - 1) begin
      if (req_vec[i]) begin
        any_req = 1'b1;
        win_idx = i[`RIVAM_IDX_W-1:0];
      end
    end
  end

endmodule // rivam_prio_enc

// *** core/rivam_regs.vh ***
// Constants for the reset and interrupt vector address generator.
// Assumes 16-bit program word addresses; included by bare name.
`ifndef RIVAM_REGS_VH
`define RIVAM_REGS_VH

// Reset vector when the boot-reset fuse is unprogrammed
`define RIVAM_RESET_ADDR        16'h0000
// First interrupt slot and slot pitch in words
`define RIVAM_TABLE_START       16'h0002
`define RIVAM_SLOT_WORDS        16'h0002
// Last slot present in legacy mode, first slot removed by it
`define RIVAM_LEGACY_LAST       16'h002E
`define RIVAM_LEGACY_CUT        16'h0030
`define RIVAM_LAST_SLOT         16'h0044
// Number of interrupt sources and index width
`define RIVAM_NUM_SRC           34
`define RIVAM_IDX_W             6
// Source index of first source removed in legacy mode
`define RIVAM_LEGACY_FIRST_IDX  23
// Default boot reset address
`define RIVAM_BOOT_RESET_DFLT   16'hF000
// Fuse encoding: 0 programmed, 1 unprogrammed
`define RIVAM_FUSE_PROGRAMMED   1'b0
// Arbiter state encodings, one-hot
`define RIVAM_ST_IDLE           3'b001
`define RIVAM_ST_HOLD           3'b010
`define RIVAM_ST_RESET          3'b100

`endif

// *** core/rivam_vector_gen.v ***
// Reset and interrupt vector address generator facing the core fetch unit.
// Assumes pending requests are levels already gated by their enables and
// that the core raises vector_ack for one cycle when it takes the vector.
`timescale 1ns/1ns
`include "rivam_regs.vh"

module rivam_vector_gen (
  // Clock and reset
  input  wire                      core_clk,
  input  wire                      rstn,
  // Configuration from fuses and the core control register
  input  wire                      boot_reset_fuse,
  input  wire                      legacy_mode_fuse,
  input  wire                      vector_table_select,
  input  wire [15:0]               boot_reset_addr,
  // Interrupt requests: external lines
  input  wire [7:0]                external_request_line,
  // Timer sources
  input  wire                      timer2_compare_event,
  input  wire                      timer2_overflow_event,
  input  wire                      timer1_capture_event,
  input  wire                      timer1_compare_a_event,
  input  wire                      timer1_compare_b_event,
  input  wire                      timer1_overflow_event,
  input  wire                      timer0_compare_event,
  input  wire                      timer0_overflow_event,
  // Serial, converter and memory sources
  input  wire                      serial_transfer_done_event,
  input  wire                      serial0_rx_done_event,
  input  wire                      serial0_tx_buffer_empty_event,
  input  wire                      serial0_tx_done_event,
  input  wire                      converter_done_event,
  input  wire                      eeprom_ready_event,
  input  wire                      analog_compare_event,
  // Extended sources, absent in legacy mode
  input  wire                      timer1_compare_c_event,
  input  wire                      timer3_capture_event,
  input  wire                      timer3_compare_a_event,
  input  wire                      timer3_compare_b_event,
  input  wire                      timer3_compare_c_event,
  input  wire                      timer3_overflow_event,
  input  wire                      serial1_rx_done_event,
  input  wire                      serial1_tx_buffer_empty_event,
  input  wire                      serial1_tx_done_event,
  input  wire                      two_wire_interface,
  input  wire                      self_program_ready_event,
  // Core handshake
  input  wire                      vector_ack,
  // Vector out
  output reg                       reset_fetch_reg,
  output reg                       vector_valid_reg,
  output reg  [15:0]               vector_addr_reg,
  output reg  [`RIVAM_IDX_W-1:0]   vector_index_reg,
  output reg  [15:0]               table_base_reg
);

  localparam [2:0] ST_IDLE  = `RIVAM_ST_IDLE;
  localparam [2:0] ST_HOLD  = `RIVAM_ST_HOLD;
  localparam [2:0] ST_RESET = `RIVAM_ST_RESET;

  // Slot address of a source index: start plus two words per index
  function [15:0] slot_addr;
    input [`RIVAM_IDX_W-1:0] idx;
    begin
      slot_addr = `RIVAM_TABLE_START + {9'h000, idx, 1'b0};
    end
  endfunction

  // Base added to every slot when the table sits in the boot section
  function [15:0] table_base;
    input        sel;
    input [15:0] boot_addr;
    begin
      if (sel) begin
        table_base = boot_addr;
      end else begin
        table_base = 16'h0000;
      end
    end
  endfunction

  reg  [2:0]                 state_reg;
  reg  [2:0]                 state_next;
  wire [`RIVAM_NUM_SRC-1:0]  raw_req;
  wire [`RIVAM_NUM_SRC-1:0]  qual_req;
  wire [`RIVAM_NUM_SRC-1:0]  legacy_mask;
  wire                       any_req;
  wire [`RIVAM_IDX_W-1:0]    win_idx;
  wire [15:0]                reset_target;
  wire [15:0]                base_now;

  // Source order equals table order, index 0 at 0x0002
  assign raw_req = {
    self_program_ready_event,      // 0x0044
    two_wire_interface,            // 0x0042
    serial1_tx_done_event,         // 0x0040
    serial1_tx_buffer_empty_event, // 0x003E
    serial1_rx_done_event,         // 0x003C
    timer3_overflow_event,         // 0x003A
    timer3_compare_c_event,        // 0x0038
    timer3_compare_b_event,        // 0x0036
    timer3_compare_a_event,        // 0x0034
    timer3_capture_event,          // 0x0032
    timer1_compare_c_event,        // 0x0030
    analog_compare_event,          // 0x002E
    eeprom_ready_event,            // 0x002C
    converter_done_event,          // 0x002A
    serial0_tx_done_event,         // 0x0028
    serial0_tx_buffer_empty_event, // 0x0026
    serial0_rx_done_event,         // 0x0024
    serial_transfer_done_event,    // 0x0022
    timer0_overflow_event,         // 0x0020
    timer0_compare_event,          // 0x001E
    timer1_overflow_event,         // 0x001C
    timer1_compare_b_event,        // 0x001A
    timer1_compare_a_event,        // 0x0018
    timer1_capture_event,          // 0x0016
    timer2_overflow_event,         // 0x0014
    timer2_compare_event,          // 0x0012
    external_request_line          // 0x0002..0x0010
  };

  // Legacy mode drops the upper slots so they are never dispatched
  genvar g;
  generate
    for (g = 0; g < `RIVAM_NUM_SRC; g = g + 1) begin : g_mask
      if (g >= `RIVAM_LEGACY_FIRST_IDX) begin : g_up
        assign legacy_mask[g] = ~legacy_mode_fuse;
      end else begin : g_lo
        assign legacy_mask[g] = 1'b1;
      end
    end
  endgenerate

  assign qual_req = raw_req & legacy_mask;

  rivam_prio_enc u_prio (
    .req_vec (qual_req),
    .any_req (any_req),
    .win_idx (win_idx)
  );

  // Reset target follows the fuse only, never the select bit
  assign reset_target = (boot_reset_fuse == `RIVAM_FUSE_PROGRAMMED) ?
                        boot_reset_addr : `RIVAM_RESET_ADDR;
  assign base_now = table_base(vector_table_select, boot_reset_addr);

  // Next state: reset fetch first, then offer one vector until taken
  always @* begin
    case (state_reg)
      ST_RESET: begin
        state_next = vector_ack ? ST_IDLE : ST_RESET;
      end
      ST_IDLE: begin
        state_next = any_req ? ST_HOLD : ST_IDLE;
      end
      ST_HOLD: begin
        state_next = vector_ack ? ST_IDLE : ST_HOLD;
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // Vector registers; a held vector is frozen so the core sees a stable
  // address even if a higher request arrives while it is being taken
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_reg        <= ST_RESET;
      reset_fetch_reg  <= 1'b1;
      vector_valid_reg <= 1'b1;
      vector_addr_reg  <= `RIVAM_RESET_ADDR;
      vector_index_reg <= {`RIVAM_IDX_W{1'b0}};
      table_base_reg   <= 16'h0000;
    end else begin
      state_reg      <= state_next;
      table_base_reg <= base_now + `RIVAM_TABLE_START;
      case (state_reg)
        ST_RESET: begin
          vector_addr_reg  <= reset_target;
          vector_index_reg <= {`RIVAM_IDX_W{1'b0}};
          reset_fetch_reg  <= ~vector_ack;
          vector_valid_reg <= ~vector_ack;
        end
        ST_IDLE: begin
          reset_fetch_reg  <= 1'b0;
          vector_valid_reg <= any_req;
          vector_index_reg <= win_idx + 6'h01;
          vector_addr_reg  <= base_now + slot_addr(win_idx);
        end
        ST_HOLD: begin
          reset_fetch_reg  <= 1'b0;
          vector_valid_reg <= ~vector_ack;
        end
        default: begin
          reset_fetch_reg  <= 1'b0;
          vector_valid_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule // rivam_vector_gen

// *** sim/reset_irq_vector_address_map_bench.sv ***
// Self-checking bench for the vector generator with a core model.
// Assumes the core model takes every offer; inputs change on falling edges.
`timescale 1ns/1ns
module reset_irq_vector_address_map_bench;
  reg         core_clk, rstn, fuse, leg, sel;
  reg  [33:0] rq;
  reg  [41:0] rows [0:5];
  wire        ack, rfetch, valid;
  wire [15:0] addr, tbase;
  wire [5:0]  idx;
  integer     failures, cmp_count, i, n;
  localparam [15:0] boot_addr = 16'hE000;

  rivam_vector_gen DUT (.core_clk(core_clk), .rstn(rstn), .boot_reset_fuse(fuse), .legacy_mode_fuse(leg),
    .vector_table_select(sel), .boot_reset_addr(boot_addr), .external_request_line(rq[7:0]),
    .timer2_compare_event(rq[8]), .timer2_overflow_event(rq[9]), .timer1_capture_event(rq[10]),
    .timer1_compare_a_event(rq[11]), .timer1_compare_b_event(rq[12]), .timer1_overflow_event(rq[13]),
    .timer0_compare_event(rq[14]), .timer0_overflow_event(rq[15]), .serial_transfer_done_event(rq[16]),
    .serial0_rx_done_event(rq[17]), .serial0_tx_buffer_empty_event(rq[18]), .serial0_tx_done_event(rq[19]),
    .converter_done_event(rq[20]), .eeprom_ready_event(rq[21]), .analog_compare_event(rq[22]),
    .timer1_compare_c_event(rq[23]), .timer3_capture_event(rq[24]), .timer3_compare_a_event(rq[25]),
    .timer3_compare_b_event(rq[26]), .timer3_compare_c_event(rq[27]), .timer3_overflow_event(rq[28]),
    .serial1_rx_done_event(rq[29]), .serial1_tx_buffer_empty_event(rq[30]), .serial1_tx_done_event(rq[31]),
    .two_wire_interface(rq[32]), .self_program_ready_event(rq[33]), .vector_ack(ack),
    .reset_fetch_reg(rfetch), .vector_valid_reg(valid), .vector_addr_reg(addr), .vector_index_reg(idx),
    .table_base_reg(tbase));
  rivam_core_model u_core (.core_clk(core_clk), .rstn(rstn), .slow(sel), .vector_valid_reg(valid),
    .vector_ack(ack));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare one observed value with its expectation
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Raise requests, await the offer, let the core take it, then drop them
  task run(input [33:0] r, input s, input l, input [5:0] x);
    begin
      @(negedge core_clk);
      rq = r;
      sel = s;
      leg = l;
      n = 0;
      while (!(valid && !rfetch) && n < 12) begin
        @(negedge core_clk);
        n = n + 1;
      end
      // A missing offer must fail, not leave a stale address to match
      if (x == 6'h00) begin
        chk({15'h0000, valid}, 16'h0000);
      end else begin
        chk({15'h0000, valid}, 16'h0001);
        chk(addr, (s ? boot_addr : 16'h0000) + {9'h000, x, 1'b0});
        chk({10'h000, idx}, {10'h000, x});
        chk(tbase, (s ? boot_addr : 16'h0000) + 16'h0002);
      end
      n = 0;
      while (!ack && x != 6'h00 && n < 12) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (x != 6'h00)
        chk({15'h0000, ack}, 16'h0001);
      @(negedge core_clk);
      rq = 34'h0_0000_0000;
      repeat (3) @(negedge core_clk);
      $display("test done: vector %0d", x);
    end
  endtask

  // Print counts and verdict, then stop
  task close_out;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #60000;
    failures = failures + 1;
    close_out;
  end

  // Main sequence: reset, priority rows, every source, relocated reset
  initial begin
    failures = 0;
    cmp_count = 0;
    rstn = 1'b0;
    fuse = 1'b1;
    leg = 1'b0;
    sel = 1'b0;
    rq = 34'h0_0000_0000;
    rows[0] = {34'h0_0000_0001, 1'b0, 1'b0, 6'h01};
    rows[1] = {34'h3_0000_0000, 1'b1, 1'b0, 6'h21};
    rows[2] = {34'h0_0080_0080, 1'b0, 1'b0, 6'h08};
    rows[3] = {34'h0_0080_0000, 1'b0, 1'b1, 6'h00};
    rows[4] = {34'h0_00C0_0000, 1'b1, 1'b1, 6'h17};
    rows[5] = {34'h2_0000_0000, 1'b1, 1'b0, 6'h22};
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(addr, 16'h0000);
    chk({15'h0000, rfetch}, 16'h0001);
    $display("test done: reset to zero");
    for (i = 0; i < 6; i = i + 1)
      run(rows[i][41:8], rows[i][7], rows[i][6], rows[i][5:0]);
    for (i = 0; i < 34; i = i + 1)
      run(34'h0_0000_0001 << i, i[0], 1'b0, i[5:0] + 6'h01);
    rstn = 1'b0;
    fuse = 1'b0;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(addr, boot_addr);
    chk({15'h0000, rfetch}, 16'h0001);
    $display("test done: reset to boot section");
    run(34'h0_0000_0002, 1'b0, 1'b0, 6'h02);
    close_out;
  end
endmodule // reset_irq_vector_address_map_bench

// *** sim/rivam_core_model.sv ***
// Fetch-side core model: takes each offered vector with a one-cycle pulse.
// Assumes the generator holds its offer until taken.
`timescale 1ns/1ns
module rivam_core_model (
  // Clock, reset, pace select and offer
  input  wire core_clk, rstn, slow, vector_valid_reg,
  // Take pulse
  output reg  vector_ack
);
  reg [1:0] wait_reg;
  // Slow pace stalls three cycles so hold behaviour is exercised
  always @(posedge core_clk) begin
    if (!rstn || vector_ack || !vector_valid_reg) begin
      vector_ack <= 1'b0;
      wait_reg   <= 2'h0;
    end else if (wait_reg == (slow ? 2'h3 : 2'h0)) begin
      vector_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule // rivam_core_model

// *** sim/rivam_vector_gen_properties.sv ***
// Checker on the vector generator ports, bound into every instance.
// Assumes configuration inputs stay steady while a vector is offered.
`timescale 1ns/1ns
module rivam_vector_gen_properties (
  // Clock and reset
  input wire        core_clk, rstn,
  // Configuration
  input wire        boot_reset_fuse, legacy_mode_fuse, vector_table_select,
  input wire [15:0] boot_reset_addr,
  // Requests and core handshake
  input wire [7:0]  external_request_line,
  input wire        vector_ack, reset_fetch_reg, vector_valid_reg,
  // Offered vector
  input wire [15:0] vector_addr_reg, table_base_reg,
  input wire [5:0]  vector_index_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Reset target; first cycle after release still shows the reset value
  property p_reset_target; $past(rstn) && reset_fetch_reg
    |-> vector_addr_reg == (boot_reset_fuse ? 16'h0000 : boot_reset_addr); endproperty
  a_reset_target: assert property (p_reset_target) else $error("reset target wrong");
  property p_vector_addr; vector_valid_reg && !reset_fetch_reg |-> vector_addr_reg ==
    (vector_table_select ? boot_reset_addr : 16'h0000) + {9'h000, vector_index_reg, 1'b0}; endproperty
  a_vector_addr: assert property (p_vector_addr) else $error("vector address wrong");
  property p_legacy_cut; legacy_mode_fuse && vector_valid_reg && !reset_fetch_reg
    |-> vector_index_reg < 6'h18; endproperty
  a_legacy_cut: assert property (p_legacy_cut) else $error("legacy vector offered");
  // Offer must not move before the core takes it
  property p_offer_hold; $past(rstn) && vector_valid_reg && !vector_ack
    |=> vector_valid_reg && $stable(vector_addr_reg); endproperty
  a_offer_hold: assert property (p_offer_hold) else $error("offer changed early");
  property p_reset_taken; reset_fetch_reg && vector_ack |=> !vector_valid_reg && !reset_fetch_reg; endproperty
  a_reset_taken: assert property (p_reset_taken) else $error("reset offer kept");
  property p_table_base; $past(rstn) |-> table_base_reg ==
    ($past(vector_table_select) ? $past(boot_reset_addr) + 16'h0002 : 16'h0002); endproperty
  a_table_base: assert property (p_table_base) else $error("table base wrong");
  property p_prio; $rose(vector_valid_reg) && !reset_fetch_reg && vector_index_reg > 6'h08
    |-> $past(external_request_line) == 8'h00; endproperty
  a_prio: assert property (p_prio) else $error("lower vector skipped");
  property p_ext_first; $rose(vector_valid_reg) && !reset_fetch_reg && $past(external_request_line[0])
    |-> vector_index_reg == 6'h01; endproperty
  a_ext_first: assert property (p_ext_first) else $error("line 0 not first");
endmodule // rivam_vector_gen_properties

bind rivam_vector_gen rivam_vector_gen_properties u_props (.*);
